// file: hdl/framer_defines.svh
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH
`define START_DELIM 8'h02
`define END_DELIM 8'h03
`define TYPE_REQUEST 8'h52
`define TYPE_CONFIRM 8'h43
`define TYPE_INDICATION 8'h69
`define TYPE_RESPONSE 8'h72
`define MAX_PAYLOAD 16'h014D
`define LEN_W 16
`define BYTE_W 8
`define PIN_SYNC_W 2
`define PIN_SYNC_RST 2'h1
`define RTS_N_RST 1'h0
`define TL_EN_RST 1'h1
`endif

// file: hdl/framer_pkg.sv
`include "framer_defines.svh"
package framer_pkg;
	typedef logic [`BYTE_W-1:0] byte_t;
	typedef logic [`LEN_W-1:0] len_t;
	typedef enum logic [3:0] {
		TX_IDLE, TX_STX, TX_TYPE, TX_OP, TX_LENL, TX_LENH, TX_CHK, TX_DATA, TX_ETX
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_HUNT, RX_TYPE, RX_OP, RX_LENL, RX_LENH, RX_CHK, RX_DATA, RX_ETX
	} rx_state_t;
	typedef enum logic [1:0] {WK_ON, WK_OFF, WK_WAIT} wake_state_t;
	typedef struct packed {
		tx_state_t tx_st;
		byte_t tx_type;
		byte_t tx_op;
		len_t tx_len;
		byte_t tx_chk;
		len_t tx_cnt;
		byte_t tx_data;
		logic tx_valid;
		logic cmd_ack;
		logic cmd_reject;
		logic pay_ack;
		rx_state_t rx_st;
		byte_t rx_type;
		byte_t rx_op;
		len_t rx_len;
		len_t rx_cnt;
		byte_t rx_sum;
		byte_t rx_byte;
		logic rx_byte_valid;
		logic rx_hdr_valid;
		logic rx_done;
		logic rx_err;
		wake_state_t wk_st;
		logic dis_pend;
		logic tl_enabled;
		logic rts_n;
	} top_state_t;
endpackage

// file: hdl/sync_if.sv
`timescale 1ns/10ps
interface sync_if #(parameter int W = 2);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync(input raw, output clean);
	modport user(output raw, input clean);
endinterface

// file: hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	sync_if.sync pins // Raw pins in, filtered levels out.
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] clean;
	} sync_state_t;
	sync_state_t s_reg;
	sync_state_t s_next;
	// A level is only taken once the second and third stages agree, which
	// rejects a single sample caught mid-transition.
	always_comb begin
		s_next = s_reg;
		s_next.s1 = pins.raw;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (s_reg.s2[i] == s_reg.s3[i]) begin
				s_next.clean[i] = s_reg.s3[i];
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= {RST, RST, RST, RST};
		end else begin
			s_reg <= s_next;
		end
	end
	assign pins.clean = s_reg.clean;
endmodule

// file: hdl/host_framer.sv
`timescale 1ns/10ps
`include "framer_defines.svh"
// Function
// - Host watches CTS while link disabled.
// - Host asserts RTS to wake device.
// - Host holds commands until enabled event.
// - Transparent mode: no framing, raw bytes.
// - Packets start 0x02, end 0x03.
// - Fixed field order, type through end.
// - Length counts payload, at most 333.
// - Checksum: low byte of header sum.
// - Request 0x52, confirm 0x43.
// - Indication 0x69, response 0x72.
// - Opcode is an opaque command code.
module host_framer #(
	parameter framer_pkg::byte_t DISABLE_OP = 8'h00, // Opcode that disables the link.
	parameter framer_pkg::byte_t TL_EN_OP = 8'h00 // Opcode of the link-enabled event.
) (
	input wire logic mclk, // System clock, 10 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic transparent, // High selects unframed byte passing.
	input wire logic cmd_valid, // Command header offered.
	input wire framer_pkg::byte_t cmd_type, // Packet type to send.
	input wire framer_pkg::byte_t cmd_opcode, // Opcode to send.
	input wire framer_pkg::len_t cmd_len, // Payload length to send.
	output logic cmd_ack, // Pulse: header taken.
	output logic cmd_reject, // Pulse with ack: length too large.
	input wire logic pay_valid, // Payload byte offered.
	input wire framer_pkg::byte_t pay_data, // Payload byte.
	output logic pay_ack, // Pulse: payload byte taken.
	output framer_pkg::byte_t tx_data, // Byte to the UART transmitter.
	output logic tx_valid, // Byte on tx_data is valid.
	input wire logic tx_ready, // UART transmitter takes the byte.
	input wire logic rx_valid, // Byte received by the UART.
	input wire framer_pkg::byte_t rx_data, // Received byte.
	output framer_pkg::byte_t rx_type, // Type of the current packet.
	output framer_pkg::byte_t rx_opcode, // Opcode of the current packet.
	output framer_pkg::len_t rx_len, // Length of the current packet.
	output logic rx_hdr_valid, // Pulse: header checked good.
	output framer_pkg::byte_t rx_byte, // Payload or transparent byte.
	output logic rx_byte_valid, // Pulse: rx_byte is new.
	output logic rx_done, // Pulse: packet closed correctly.
	output logic rx_err, // Pulse: packet discarded.
	input wire logic cts_n, // Pin: device RTS, active low.
	input wire logic host_wake_in, // Pin: device wake line, active high.
	output logic rts_n, // Pin: host RTS to device CTS, active low.
	output logic tl_enabled // Link layer known to be enabled.
);
	import framer_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	sync_if #(.W(`PIN_SYNC_W)) pins ();
	assign pins.raw = {host_wake_in, cts_n};
	pin_sync #(.W(`PIN_SYNC_W), .RST(`PIN_SYNC_RST)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pins(pins)
	);
	logic dev_wants_host;
	assign dev_wants_host = pins.clean[1] || !pins.clean[0];

	top_state_t s_reg;
	top_state_t s_next;
	logic slot_free;
	assign slot_free = !s_reg.tx_valid || tx_ready;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.cmd_ack = 1'b0;
		s_next.cmd_reject = 1'b0;
		s_next.pay_ack = 1'b0;
		s_next.rx_byte_valid = 1'b0;
		s_next.rx_hdr_valid = 1'b0;
		s_next.rx_done = 1'b0;
		s_next.rx_err = 1'b0;
		if (s_reg.tx_valid && tx_ready) begin
			s_next.tx_valid = 1'b0;
		end
		// Transmit side.
		case (s_reg.tx_st)
			TX_IDLE: begin
				if (transparent) begin
					if (slot_free && pay_valid && !s_reg.pay_ack) begin
						s_next.tx_data = pay_data;
						s_next.tx_valid = 1'b1;
						s_next.pay_ack = 1'b1;
					end
				end else if (cmd_valid && !s_reg.cmd_ack && s_reg.wk_st == WK_ON) begin
					s_next.cmd_ack = 1'b1;
					if (cmd_len > `MAX_PAYLOAD) begin
						s_next.cmd_reject = 1'b1;
					end else begin
						s_next.tx_type = cmd_type;
						s_next.tx_op = cmd_opcode;
						s_next.tx_len = cmd_len;
						s_next.tx_cnt = '0;
						s_next.tx_chk = cmd_type + cmd_opcode + cmd_len[7:0] + cmd_len[15:8];
						s_next.tx_st = TX_STX;
						if (cmd_type == `TYPE_REQUEST && cmd_opcode == DISABLE_OP) begin
							s_next.dis_pend = 1'b1;
						end
					end
				end
			end
			TX_DATA: begin
				if (s_reg.tx_cnt == s_reg.tx_len) begin
					s_next.tx_st = TX_ETX;
				end else if (slot_free && pay_valid && !s_reg.pay_ack) begin
					s_next.tx_data = pay_data;
					s_next.tx_valid = 1'b1;
					s_next.pay_ack = 1'b1;
					s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
				end
			end
			default: begin
				if (slot_free) begin
					s_next.tx_valid = 1'b1;
					case (s_reg.tx_st)
						TX_STX: begin
							s_next.tx_data = `START_DELIM;
							s_next.tx_st = TX_TYPE;
						end
						TX_TYPE: begin
							s_next.tx_data = s_reg.tx_type;
							s_next.tx_st = TX_OP;
						end
						TX_OP: begin
							s_next.tx_data = s_reg.tx_op;
							s_next.tx_st = TX_LENL;
						end
						TX_LENL: begin
							s_next.tx_data = s_reg.tx_len[7:0];
							s_next.tx_st = TX_LENH;
						end
						TX_LENH: begin
							s_next.tx_data = s_reg.tx_len[15:8];
							s_next.tx_st = TX_CHK;
						end
						TX_CHK: begin
							s_next.tx_data = s_reg.tx_chk;
							s_next.tx_st = TX_DATA;
						end
						default: begin
							s_next.tx_data = `END_DELIM;
							s_next.tx_st = TX_IDLE;
						end
					endcase
				end
			end
		endcase
		// Receive side.
		if (rx_valid) begin
			if (transparent) begin
				s_next.rx_byte = rx_data;
				s_next.rx_byte_valid = 1'b1;
				s_next.rx_st = RX_HUNT;
			end else begin
				case (s_reg.rx_st)
					RX_HUNT: begin
						if (rx_data == `START_DELIM) begin
							s_next.rx_st = RX_TYPE;
						end
					end
					RX_TYPE: begin
						s_next.rx_type = rx_data;
						s_next.rx_sum = rx_data;
						s_next.rx_st = RX_OP;
					end
					RX_OP: begin
						s_next.rx_op = rx_data;
						s_next.rx_sum = s_reg.rx_sum + rx_data;
						s_next.rx_st = RX_LENL;
					end
					RX_LENL: begin
						s_next.rx_len = {8'h00, rx_data};
						s_next.rx_sum = s_reg.rx_sum + rx_data;
						s_next.rx_st = RX_LENH;
					end
					RX_LENH: begin
						s_next.rx_len = {rx_data, s_reg.rx_len[7:0]};
						s_next.rx_sum = s_reg.rx_sum + rx_data;
						s_next.rx_st = RX_CHK;
					end
					RX_CHK: begin
						s_next.rx_cnt = '0;
						if (rx_data != s_reg.rx_sum || s_reg.rx_len > `MAX_PAYLOAD) begin
							s_next.rx_err = 1'b1;
							s_next.rx_st = RX_HUNT;
						end else begin
							s_next.rx_hdr_valid = 1'b1;
							s_next.rx_st = (s_reg.rx_len == '0) ? RX_ETX : RX_DATA;
						end
					end
					RX_DATA: begin
						s_next.rx_byte = rx_data;
						s_next.rx_byte_valid = 1'b1;
						s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
						if (s_reg.rx_cnt + 16'h0001 == s_reg.rx_len) begin
							s_next.rx_st = RX_ETX;
						end
					end
					default: begin
						s_next.rx_st = RX_HUNT;
						if (rx_data == `END_DELIM) begin
							s_next.rx_done = 1'b1;
						end else begin
							s_next.rx_err = 1'b1;
						end
					end
				endcase
			end
		end
		// Wake-up handshake.
		case (s_reg.wk_st)
			WK_ON: begin
				if (s_next.rx_done && s_reg.dis_pend && s_reg.rx_op == DISABLE_OP
					&& s_reg.rx_type == `TYPE_CONFIRM) begin
					// A header taken as the link closes would go to a sleeping device.
					// It is left offered instead, so it starts the wake-up next.
					if (s_reg.tx_st == TX_IDLE && !transparent) begin
						s_next.cmd_ack = 1'b0;
						s_next.cmd_reject = 1'b0;
						s_next.tx_st = TX_IDLE;
					end
					s_next.dis_pend = 1'b0;
					s_next.tl_enabled = 1'b0;
					s_next.rts_n = 1'b1;
					s_next.wk_st = WK_OFF;
				end
			end
			WK_OFF: begin
				if ((cmd_valid && !transparent) || dev_wants_host) begin
					s_next.rts_n = 1'b0;
					s_next.wk_st = WK_WAIT;
				end
			end
			default: begin
				// Either a confirm or an indication may carry the enabled event.
				if (s_next.rx_done && s_reg.rx_op == TL_EN_OP
					&& (s_reg.rx_type == `TYPE_CONFIRM
					|| s_reg.rx_type == `TYPE_INDICATION)) begin
					s_next.tl_enabled = 1'b1;
					s_next.wk_st = WK_ON;
				end
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.tx_st <= TX_IDLE;
			s_reg.rx_st <= RX_HUNT;
			s_reg.wk_st <= WK_ON;
			s_reg.rts_n <= `RTS_N_RST;
			s_reg.tl_enabled <= `TL_EN_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_ack = s_reg.cmd_ack;
	assign cmd_reject = s_reg.cmd_reject;
	assign pay_ack = s_reg.pay_ack;
	assign tx_data = s_reg.tx_data;
	assign tx_valid = s_reg.tx_valid;
	assign rx_type = s_reg.rx_type;
	assign rx_opcode = s_reg.rx_op;
	assign rx_len = s_reg.rx_len;
	assign rx_hdr_valid = s_reg.rx_hdr_valid;
	assign rx_byte = s_reg.rx_byte;
	assign rx_byte_valid = s_reg.rx_byte_valid;
	assign rx_done = s_reg.rx_done;
	assign rx_err = s_reg.rx_err;
	assign rts_n = s_reg.rts_n;
	assign tl_enabled = s_reg.tl_enabled;
endmodule

// file: verif/framer_asserts.sv
`timescale 1ns/10ps
// ****************************************
// Port checks of the host framer
// ****************************************
module framer_asserts (
	input wire logic mclk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic transparent, // Raw mode.
	input wire logic cmd_valid, // Header offered.
	input wire framer_pkg::len_t cmd_len, // Header length.
	input wire logic cmd_ack, // Header taken.
	input wire logic cmd_reject, // Header refused.
	input wire framer_pkg::byte_t tx_data, // Byte out.
	input wire logic tx_valid, // Byte out valid.
	input wire logic tx_ready, // Byte out taken.
	input wire logic rx_valid, // Byte in strobe.
	input wire framer_pkg::byte_t rx_data, // Byte in.
	input wire framer_pkg::byte_t rx_byte, // Byte delivered.
	input wire logic rx_byte_valid, // Delivery strobe.
	input wire logic rx_done, // Packet closed.
	input wire logic rts_n, // Host request, active low.
	input wire logic tl_enabled // Link enabled.
);
	import framer_pkg::*;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	reject_len_a: assert property (cmd_ack |-> cmd_reject == (cmd_len > 16'h014D))
		else $error("reject flag wrong");
	stx_first_a: assert property (cmd_ack && !cmd_reject && (!tx_valid || tx_ready)
		|=> tx_valid && tx_data == 8'h02)
		else $error("start byte missing");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte out not held");
	end_delim_a: assert property (rx_done |-> $past(rx_valid) && $past(rx_data) == 8'h03)
		else $error("close without end byte");
	raw_pass_a: assert property (transparent && rx_valid
		|=> rx_byte_valid && rx_byte == $past(rx_data))
		else $error("raw byte lost");
	sleep_lines_a: assert property ($fell(tl_enabled) |-> rts_n)
		else $error("request kept in sleep");
	wake_req_a: assert property (!tl_enabled && rts_n && cmd_valid && !transparent |=> !rts_n)
		else $error("no wake request");
	hold_cmds_a: assert property (!tl_enabled |-> !cmd_ack)
		else $error("command taken asleep");
endmodule
bind host_framer framer_asserts chk_u (.*);

// file: verif/device_model.sv
`timescale 1ns/10ps
// ****************************************
// Device side of the serial link
// ****************************************
module device_model #(
	parameter framer_pkg::byte_t DIS = 8'h4F, // Sleep opcode.
	parameter framer_pkg::byte_t TLE = 8'h50 // Link-enabled opcode.
) (
	input wire logic mclk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire framer_pkg::byte_t tx_data, // Byte from host.
	input wire logic tx_valid, // Byte offered.
	output logic tx_ready, // Byte taken.
	output logic rx_valid, // Byte strobe to host.
	output framer_pkg::byte_t rx_data, // Byte to host.
	output logic cts_n, // Device request, active low.
	output logic host_wake_in, // Device wake line.
	input wire logic rts_n // Host request, active low.
);
	import framer_pkg::*;
	byte_t got_q[$], cur[$], op_q[$];
	logic [16:0] ind_q[$];
	logic [16:0] e;
	logic off = 0;
	logic busy = 0;
	int seed = 32'h1D3;
	byte_t p;
	task automatic put(input byte_t b);
		rx_data = b;
		rx_valid = 1;
		@(posedge mclk);
		#5 rx_valid = 0;
		// A released line shows the inverse, so a stale byte is never reused.
		rx_data = ~b;
		@(posedge mclk);
		#5;
	endtask
	task automatic pkt(input byte_t t, input byte_t o, input byte_t n, input logic bad);
		put(8'h02);
		put(t);
		put(o);
		put(n);
		put(8'h00);
		put(byte_t'(t + o + n) ^ {7'h00, bad});
		for (int i = 0; i < n; i++) put(byte_t'(o + i));
		put(8'h03);
	endtask
	task automatic wake();
		off = 0;
		cts_n = 0;
		host_wake_in = 1;
		pkt(8'h43, TLE, 8'h00, 1'b0);
	endtask
	initial begin
		tx_ready = 0;
		forever begin
			@(posedge mclk);
			if (tx_valid === 1'b1 && tx_ready) begin
				got_q.push_back(tx_data);
				if (cur.size() > 0 || tx_data == 8'h02) cur.push_back(tx_data);
				if (cur.size() > 4 && cur.size() == {cur[4], cur[3]} + 7) begin
					if (cur[1] == 8'h52) op_q.push_back(cur[2]);
					cur.delete();
				end
			end
			#5 tx_ready = ($random(seed) & 3) != 0;
		end
	end
	initial begin
		rx_valid = 0;
		rx_data = 8'hA5;
		cts_n = 0;
		host_wake_in = 0;
		forever begin
			@(posedge mclk);
			#5;
			if (op_q.size() > 0) begin
				p = op_q.pop_front();
				// Lines drop first so the host cannot take the old level as a wake-up.
				if (p == DIS) begin
					off = 1;
					cts_n = 1;
					host_wake_in = 0;
				end
				pkt(8'h43, p, 8'h00, 1'b0);
			end else if (off && rts_n === 1'b0) begin
				wake();
			end else if (ind_q.size() > 0) begin
				busy = 1;
				e = ind_q.pop_front();
				if (off) begin
					cts_n = 0;
					host_wake_in = 1;
					for (int k = 0; k < 100 && rts_n !== 1'b0; k++) @(posedge mclk);
					#5 wake();
				end
				pkt(8'h69, e[15:8], e[7:0], e[16]);
				busy = 0;
			end
		end
	end
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	import framer_pkg::*;
	localparam byte_t DIS = 8'h4F;
	localparam byte_t TLE = 8'h50;
	logic mclk = 0, rst_n = 0, transparent = 0, cmd_valid = 0, pay_valid = 0;
	byte_t cmd_type = 8'h00, cmd_opcode = 8'h00, pay_data = 8'h00;
	len_t cmd_len = 16'h0000;
	logic cmd_ack, cmd_reject, pay_ack, tx_valid, tx_ready, rx_valid, rx_hdr_valid;
	logic rx_byte_valid, rx_done, rx_err, cts_n, host_wake_in, rts_n, tl_enabled;
	byte_t tx_data, rx_data, rx_type, rx_opcode, rx_byte;
	len_t rx_len;
	int seed = 32'h58E2;
	int err_count = 0, checks_done = 0, n_hdr = 0, n_err = 0;
	int lens[4] = '{0, 1, 5, 333};
	byte_t exp_q[$], rb_q[$];
	host_framer #(.DISABLE_OP(DIS), .TL_EN_OP(TLE)) dut_u (.*);
	device_model #(.DIS(DIS), .TLE(TLE)) dev (.*);
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (rx_hdr_valid === 1'b1) n_hdr++;
		if (rx_err === 1'b1) n_err++;
		if (rx_byte_valid === 1'b1) rb_q.push_back(rx_byte);
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic tick(inout int k);
		@(posedge mclk);
		k++;
		if (k > 3000) begin
			err_count++;
			$display("MISMATCH %0t wait ran out", $time);
			end_sim();
		end
	endtask
	task automatic pay(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			pay_data = byte_t'($random(seed)) | 8'h10;
			pay_valid = 1;
			while (pay_ack !== 1'b1) tick(k);
			#5;
			exp_q.push_back(pay_data);
		end
		pay_valid = 0;
	endtask
	task automatic cmp();
		int k = 0;
		while (dev.got_q.size() < exp_q.size()) tick(k);
		repeat (40) @(posedge mclk);
		#5;
		chk(dev.got_q.size(), exp_q.size());
		foreach (exp_q[i]) chk(dev.got_q[i], exp_q[i]);
	endtask
	task automatic cmd(input byte_t t, input byte_t o, input len_t n, input int eh);
		int k = 0;
		int h0 = n_hdr;
		dev.got_q.delete();
		exp_q = '{8'h02, t, o, n[7:0], n[15:8], byte_t'(t + o + n[7:0] + n[15:8])};
		cmd_type = t;
		cmd_opcode = o;
		cmd_len = n;
		cmd_valid = 1;
		while (cmd_ack !== 1'b1) tick(k);
		chk(cmd_reject, n > 333);
		#5 cmd_valid = 0;
		if (n > 333) exp_q.delete();
		else begin
			pay(n);
			exp_q.push_back(8'h03);
		end
		cmp();
		chk(n_hdr - h0, eh);
		if (eh > 0) chk({rx_type, rx_opcode}, {8'h43, o});
		if (eh > 0) chk(rx_len, 16'h0000);
	endtask
	task automatic indication_packet(input logic [16:0] e, input int eh, input int ee);
		int k = 0;
		int h0 = n_hdr;
		int e0 = n_err;
		rb_q.delete();
		dev.ind_q.push_back(e);
		while (dev.ind_q.size() > 0 || dev.busy) tick(k);
		repeat (10) @(posedge mclk);
		#5;
		chk(n_hdr - h0, eh);
		chk(n_err - e0, ee);
		chk(rb_q.size(), transparent ? e[7:0] + 7 : (ee > 0 ? 0 : e[7:0]));
		if (!transparent && ee == 0) foreach (rb_q[i]) chk(rb_q[i], byte_t'(e[15:8] + i));
		if (!transparent && ee == 0) chk(rx_len, {8'h00, e[7:0]});
	endtask
	initial begin
		#155 rst_n = 1;
		chk(tl_enabled, 1);
		chk(rts_n, 0);
		foreach (lens[i]) cmd(8'h52, byte_t'($random(seed)) | 8'h80, len_t'(lens[i]), 1);
		$display("requests done");
		cmd(8'h72, 8'h91, 16'h0003, 0);
		cmd(8'h52, 8'h92, 16'h014E, 0);
		$display("response and refusal done");
		indication_packet({1'b0, 8'h3C, 8'h04}, 1, 0);
		indication_packet({1'b1, 8'h3D, 8'h02}, 0, 1);
		$display("indications done");
		cmd(8'h52, DIS, 16'h0000, 1);
		chk({tl_enabled, rts_n}, 2'b01);
		cmd(8'h52, 8'hA1, 16'h0002, 2);
		chk(tl_enabled, 1);
		cmd(8'h52, DIS, 16'h0000, 1);
		indication_packet({1'b0, 8'h44, 8'h03}, 2, 0);
		chk({tl_enabled, rx_type}, {1'b1, 8'h69});
		$display("sleep and wake done");
		transparent = 1;
		dev.got_q.delete();
		exp_q.delete();
		pay(2);
		cmp();
		indication_packet({1'b0, 8'h45, 8'h00}, 0, 0);
		$display("raw mode done");
		end_sim();
	end
endmodule
